// *** verilog/udr_responder.sv ***
// udr_responder: answers descriptor reads for endpoint 3, other-speed config and qualifier
// assumes the loader holds nv config stable; speed and power mode come from the core domain
`timescale 1ns/1ps
// Behaviour
// - The endpoint 3 polling interval and the loadable other-speed and qualifier fields come from nonvolatile memory; the rest is fixed.
// - Endpoint 3 reports length 07h, type 05h, address 83h and attributes 03h.
// - Endpoint 3 max packet size is 0010h, little-endian at offset 04h.
// - Separate full and high speed intervals are kept and the current speed picks one.
// - Without OTP or EEPROM the interval is 04h at HS, 01h at FS and 06h at SuperSpeed.
// - Other-speed and qualifier descriptors are served in USB 2.0 only and stalled in SuperSpeed.
// - Other-speed config has length 09h, type 07h, total 0027h, one interface, value 01h.
// - Other-speed config uses the values stored for the opposite USB 2.0 speed.
// - Other-speed attributes default to E0h, are loadable, and configuration flags may alter them.
// - Other-speed max power defaults to 01h self-powered and FAh bus-powered, and is loadable.
// - Other-speed string index defaults to 00h and may be loaded.
// - Qualifier reports length 0Ah, type 06h and a final reserved zero byte.
// - Qualifier reports release 0210h, class FFh, subclass 00h, protocol FFh unless loaded.
// - Qualifier reports endpoint-zero packet size 40h and 01h other-speed configurations.
// - Qualifier contents come from the device data of the opposite USB 2.0 speed.
module udr_responder
  import udr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // operating state
  input wire udr_speed_t speed,
  input wire logic self_powered,
  input wire udr_nvcfg_t nvcfg,
  // request and answer
  input wire udr_req_t req,
  output udr_rsp_t rsp
);
  typedef enum {UDR_ST_LOAD, UDR_ST_IDLE, UDR_ST_FETCH, UDR_ST_SEND} udr_state_t;

  udr_state_t state_q;
  logic [4:0] ld_idx_q;
  logic [4:0] rd_addr_q;
  logic [7:0] remain_q;
  logic [7:0] wr_data_d;
  logic [7:0] rsp_len_d;
  logic [4:0] base_d;
  udr_sel_t sel_d;
  udr_spdcfg_t oth;
  udr_rsp_t rsp_q;
  logic [7:0] tbl_data;
  logic [7:0] ivl_d;
  logic [7:0] attr_d;
  logic [7:0] pwr_d;
  logic [7:0] str_d;
  logic [15:0] bcd_d;
  logic [7:0] cls_d;
  logic [7:0] sub_d;
  logic [7:0] pro_d;
  udr_speed_t spd_q;
  logic pwr_q;
  logic img_stale;

  // opposite USB 2.0 speed
  assign oth = (speed == UDR_SPD_HS) ? nvcfg.fs : nvcfg.hs;

  // full speed code is tracked: FS and SS share the other-speed set but not the interval byte
  assign img_stale = (spd_q != speed) || (pwr_q != self_powered);

  always_comb begin
    if (speed == UDR_SPD_SS) begin
      ivl_d = nvcfg.nv_present ? nvcfg.hs.ivl : UDR_IVL_SS_DEF;
    end else if (!nvcfg.nv_present) begin
      ivl_d = (speed == UDR_SPD_HS) ? UDR_IVL_HS_DEF : UDR_IVL_FS_DEF;
    end else begin
      ivl_d = (speed == UDR_SPD_HS) ? nvcfg.hs.ivl : nvcfg.fs.ivl;
    end
  end

  always_comb begin
    attr_d = oth.attr_ld ? oth.attr : (UDR_OSC_ATTR_DEF | nvcfg.attr_flags);
    pwr_d = oth.pwr_ld ? oth.pwr : (self_powered ? UDR_PWR_SELF_DEF : UDR_PWR_BUS_DEF);
    str_d = oth.str_ld ? oth.str_idx : UDR_OSC_STR_DEF;
    bcd_d = oth.dev_ld ? oth.bcd : UDR_QUAL_BCD_DEF;
    cls_d = oth.dev_ld ? oth.dclass : UDR_QUAL_CLASS_DEF;
    sub_d = oth.dev_ld ? oth.dsub : UDR_QUAL_SUB_DEF;
    pro_d = oth.dev_ld ? oth.dproto : UDR_QUAL_PROTO_DEF;
  end

  // byte image of all three descriptors, written into the table
  always_comb begin
    case (ld_idx_q)
      5'h00: wr_data_d = UDR_EP_LEN;
      5'h01: wr_data_d = UDR_TYPE_EP;
      5'h02: wr_data_d = UDR_EP_ADDR;
      5'h03: wr_data_d = UDR_EP_ATTR;
      5'h04: wr_data_d = UDR_EP_MPS[7:0];
      5'h05: wr_data_d = UDR_EP_MPS[15:8];
      5'h06: wr_data_d = ivl_d;
      5'h08: wr_data_d = UDR_OSC_LEN;
      5'h09: wr_data_d = UDR_TYPE_OSC;
      5'h0a: wr_data_d = UDR_OSC_TOTAL[7:0];
      5'h0b: wr_data_d = UDR_OSC_TOTAL[15:8];
      5'h0c: wr_data_d = UDR_OSC_NUMIF;
      5'h0d: wr_data_d = UDR_OSC_CFGVAL;
      5'h0e: wr_data_d = str_d;
      5'h0f: wr_data_d = attr_d;
      5'h10: wr_data_d = pwr_d;
      5'h12: wr_data_d = UDR_QUAL_LEN;
      5'h13: wr_data_d = UDR_TYPE_QUAL;
      5'h14: wr_data_d = bcd_d[7:0];
      5'h15: wr_data_d = bcd_d[15:8];
      5'h16: wr_data_d = cls_d;
      5'h17: wr_data_d = sub_d;
      5'h18: wr_data_d = pro_d;
      5'h19: wr_data_d = UDR_QUAL_MPS0;
      5'h1a: wr_data_d = UDR_QUAL_NCFG;
      5'h1b: wr_data_d = UDR_QUAL_RSVD;
      default: wr_data_d = 8'h00;
    endcase
  end

  always_comb begin
    sel_d = UDR_SEL_NONE;
    if (req.dtype == UDR_TYPE_EP) begin
      sel_d = UDR_SEL_EP;
    end else if (req.dtype == UDR_TYPE_OSC) begin
      sel_d = UDR_SEL_OSC;
    end else if (req.dtype == UDR_TYPE_QUAL) begin
      sel_d = UDR_SEL_QUAL;
    end
    case (sel_d)
      UDR_SEL_EP: begin
        base_d = UDR_BASE_EP;
        rsp_len_d = UDR_EP_LEN;
      end
      UDR_SEL_OSC: begin
        base_d = UDR_BASE_OSC;
        rsp_len_d = UDR_OSC_LEN;
      end
      UDR_SEL_QUAL: begin
        base_d = UDR_BASE_QUAL;
        rsp_len_d = UDR_QUAL_LEN;
      end
      default: begin
        base_d = UDR_BASE_EP;
        rsp_len_d = 8'h00;
      end
    endcase
    if (req.wlength < {8'h00, rsp_len_d}) begin
      rsp_len_d = req.wlength[7:0];
    end
  end

  // speed or power change seen in IDLE or LOAD re-images the table; a change during FETCH or SEND is not caught and the old image stays
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spd_q <= UDR_SPD_FS;
      pwr_q <= 1'b0;
    end else begin
      spd_q <= speed;
      pwr_q <= self_powered;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= UDR_ST_LOAD;
      ld_idx_q <= 5'h00;
      rd_addr_q <= 5'h00;
      remain_q <= 8'h00;
    end else begin
      case (state_q)
        UDR_ST_LOAD: begin
          // a change while imaging restarts the image, else bytes already written would be stale
          if (img_stale) begin
            ld_idx_q <= 5'h00;
          end else begin
            ld_idx_q <= ld_idx_q + 5'h01;
            if (ld_idx_q == 5'h1f) begin
              state_q <= UDR_ST_IDLE;
            end
          end
        end
        UDR_ST_IDLE: begin
          if (img_stale) begin
            state_q <= UDR_ST_LOAD;
          end else if (req.valid && sel_d != UDR_SEL_NONE && !(sel_d != UDR_SEL_EP && speed == UDR_SPD_SS)
              && rsp_len_d != 8'h00) begin
            rd_addr_q <= base_d;
            remain_q <= rsp_len_d;
            state_q <= UDR_ST_FETCH;
          end
        end
        UDR_ST_FETCH: begin
          rd_addr_q <= rd_addr_q + 5'h01;
          state_q <= UDR_ST_SEND;
        end
        UDR_ST_SEND: begin
          rd_addr_q <= rd_addr_q + 5'h01;
          remain_q <= remain_q - 8'h01;
          if (remain_q == 8'h01) begin
            state_q <= UDR_ST_IDLE;
          end
        end
        default: state_q <= UDR_ST_IDLE;
      endcase
    end
  end

  udr_table u_table (
    .core_clk(core_clk),
    .wr_en(state_q == UDR_ST_LOAD),
    .wr_addr(ld_idx_q),
    .wr_data(wr_data_d),
    .rd_addr(rd_addr_q),
    .rd_data(tbl_data)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= '0;
      if (state_q == UDR_ST_SEND) begin
        rsp_q.valid <= 1'b1;
        rsp_q.data <= tbl_data;
        rsp_q.last <= (remain_q == 8'h01);
      end else if (state_q == UDR_ST_IDLE && req.valid && !img_stale
          && (sel_d == UDR_SEL_OSC || sel_d == UDR_SEL_QUAL) && speed == UDR_SPD_SS) begin
        rsp_q.valid <= 1'b1;
        rsp_q.stall <= 1'b1;
        rsp_q.last <= 1'b1;
      end
    end
  end
  assign rsp = rsp_q;

  a_stall_ss: assert property (@(posedge core_clk) disable iff (rst)
    rsp.valid && !rsp.stall |-> $past(speed) != UDR_SPD_SS || $past(state_q) == UDR_ST_SEND)
    else $error("stall rule broken");
  a_no_data_in_ss: assert property (@(posedge core_clk) disable iff (rst)
    rsp.stall |-> !$past(state_q == UDR_ST_SEND) && $past(speed) == UDR_SPD_SS)
    else $error("stall without superspeed");
  sequence s_start;
    state_q == UDR_ST_IDLE ##1 state_q == UDR_ST_FETCH;
  endsequence
  a_first_byte: assert property (@(posedge core_clk) disable iff (rst)
    s_start |-> ##2 rsp.valid)
    else $error("first byte late");
  a_ep_length: assert property (@(posedge core_clk) disable iff (rst)
    state_q == UDR_ST_SEND && rd_addr_q == 5'h01 |-> ##1 rsp.data == UDR_EP_LEN)
    else $error("endpoint length wrong");
  a_ep_mps: assert property (@(posedge core_clk) disable iff (rst)
    state_q == UDR_ST_SEND && rd_addr_q == 5'h05 |-> ##1 rsp.data == UDR_EP_MPS[7:0])
    else $error("endpoint packet size wrong");
  a_osc_type: assert property (@(posedge core_clk) disable iff (rst)
    state_q == UDR_ST_SEND && rd_addr_q == 5'h0a |-> ##1 rsp.data == UDR_TYPE_OSC)
    else $error("other-speed type wrong");
  a_qual_rsvd: assert property (@(posedge core_clk) disable iff (rst)
    state_q == UDR_ST_SEND && rd_addr_q == 5'h1c |-> ##1 rsp.data == UDR_QUAL_RSVD)
    else $error("qualifier reserved byte nonzero");
  a_qual_mps0: assert property (@(posedge core_clk) disable iff (rst)
    state_q == UDR_ST_SEND && rd_addr_q == 5'h1a |-> ##1 rsp.data == UDR_QUAL_MPS0)
    else $error("qualifier ep0 size wrong");
endmodule // udr_responder

// *** verilog/udr_pkg.sv ***
// udr_pkg: constants and carrier types for the descriptor responder
// assumes one core clock; loaded configuration values arrive already valid
package udr_pkg;
  // descriptor types
  localparam logic [7:0] UDR_TYPE_EP = 8'h05;
  localparam logic [7:0] UDR_TYPE_OSC = 8'h07;
  localparam logic [7:0] UDR_TYPE_QUAL = 8'h06;
  // endpoint 3 fixed fields
  localparam logic [7:0] UDR_EP_LEN = 8'h07;
  localparam logic [7:0] UDR_EP_ADDR = 8'h83;
  localparam logic [7:0] UDR_EP_ATTR = 8'h03;
  localparam logic [15:0] UDR_EP_MPS = 16'h0010;
  localparam logic [7:0] UDR_IVL_HS_DEF = 8'h04;
  localparam logic [7:0] UDR_IVL_FS_DEF = 8'h01;
  localparam logic [7:0] UDR_IVL_SS_DEF = 8'h06;
  // other-speed configuration fields
  localparam logic [7:0] UDR_OSC_LEN = 8'h09;
  localparam logic [15:0] UDR_OSC_TOTAL = 16'h0027;
  localparam logic [7:0] UDR_OSC_NUMIF = 8'h01;
  localparam logic [7:0] UDR_OSC_CFGVAL = 8'h01;
  localparam logic [7:0] UDR_OSC_STR_DEF = 8'h00;
  localparam logic [7:0] UDR_OSC_ATTR_DEF = 8'he0;
  localparam logic [7:0] UDR_PWR_SELF_DEF = 8'h01;
  localparam logic [7:0] UDR_PWR_BUS_DEF = 8'hfa;
  // device qualifier fields
  localparam logic [7:0] UDR_QUAL_LEN = 8'h0a;
  localparam logic [15:0] UDR_QUAL_BCD_DEF = 16'h0210;
  localparam logic [7:0] UDR_QUAL_CLASS_DEF = 8'hff;
  localparam logic [7:0] UDR_QUAL_SUB_DEF = 8'h00;
  localparam logic [7:0] UDR_QUAL_PROTO_DEF = 8'hff;
  localparam logic [7:0] UDR_QUAL_MPS0 = 8'h40;
  localparam logic [7:0] UDR_QUAL_NCFG = 8'h01;
  localparam logic [7:0] UDR_QUAL_RSVD = 8'h00;
  // table of descriptor bytes
  localparam int UDR_ROM_DEPTH = 32;
  localparam logic [4:0] UDR_BASE_EP = 5'h00;
  localparam logic [4:0] UDR_BASE_OSC = 5'h08;
  localparam logic [4:0] UDR_BASE_QUAL = 5'h12;

  typedef enum logic [1:0] {UDR_SPD_FS, UDR_SPD_HS, UDR_SPD_SS} udr_speed_t;
  typedef enum logic [1:0] {UDR_SEL_EP, UDR_SEL_OSC, UDR_SEL_QUAL, UDR_SEL_NONE} udr_sel_t;

  // per-speed configuration values taken from nonvolatile memory
  typedef struct packed {
    logic [7:0] ivl;
    logic str_ld;
    logic [7:0] str_idx;
    logic attr_ld;
    logic [7:0] attr;
    logic pwr_ld;
    logic [7:0] pwr;
    logic dev_ld;
    logic [15:0] bcd;
    logic [7:0] dclass;
    logic [7:0] dsub;
    logic [7:0] dproto;
  } udr_spdcfg_t;

  typedef struct packed {
    logic nv_present;
    logic [7:0] attr_flags;
    udr_spdcfg_t fs;
    udr_spdcfg_t hs;
  } udr_nvcfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] dtype;
    logic [15:0] wlength;
  } udr_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic stall;
  } udr_rsp_t;
endpackage

// *** verilog/udr_table.sv ***
// udr_table: small descriptor byte store with registered read data
// assumes writer and reader share core_clk
`timescale 1ns/1ps
module udr_table
  import udr_pkg::*;
(
  // clock
  input wire logic core_clk,
  // write side
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [UDR_ROM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // udr_table

// *** verif/udr_host.sv ***
// udr_host: host-side model that issues descriptor reads and gathers the answer
// assumes the responder answers within a few tens of core_clk cycles
`timescale 1ns/1ps
module udr_host
  import udr_pkg::*;
(
  // clock
  input wire logic core_clk,
  // request and answer
  output udr_req_t req,
  input wire udr_rsp_t rsp
);
  initial req = '0;

  task automatic read_desc(input logic [7:0] dt, input logic [15:0] wl, output logic [7:0] q[$],
                           output logic stalled, output logic ok);
    int n;
    q = {};
    stalled = 1'b0;
    ok = 1'b0;
    @(posedge core_clk);
    req <= '{1'b1, dt, wl};
    @(posedge core_clk);
    // released fields show the inverse so a stale request is never mistaken for a live one
    req <= '{1'b0, ~dt, ~wl};
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge core_clk);
      if (rsp.valid === 1'b1) begin
        if (rsp.stall === 1'b1) stalled = 1'b1;
        else q.push_back(rsp.data);
        if (rsp.last === 1'b1) ok = 1'b1;
      end
    end
  endtask
endmodule // udr_host

// *** verif/tb_usb_descriptor_responder_ep3_qualifier.sv ***
// tb_usb_descriptor_responder_ep3_qualifier: random descriptor reads over speeds and loaded values
// assumes the 32-cycle table image after reset or a speed change, plus a few cycles of change detection
`timescale 1ns/1ps
module tb_usb_descriptor_responder_ep3_qualifier;
  import udr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  udr_speed_t speed = UDR_SPD_FS;
  logic self_powered = 1'b0;
  udr_nvcfg_t nvcfg = '0;
  udr_req_t req;
  udr_rsp_t rsp;
  int n_errors = 0;
  int comparisons = 0;

  always #2 core_clk = ~core_clk;

  udr_responder dut (.core_clk(core_clk), .rst(rst), .speed(speed), .self_powered(self_powered),
                     .nvcfg(nvcfg), .req(req), .rsp(rsp));
  udr_host host (.core_clk(core_clk), .req(req), .rsp(rsp));

  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic void build(input logic [7:0] dt, output logic [7:0] d[$]);
    udr_spdcfg_t o;
    logic [7:0] ivl;
    o = (speed == UDR_SPD_FS) ? nvcfg.hs : nvcfg.fs;
    ivl = (speed == UDR_SPD_HS) ? 8'h04 : (speed == UDR_SPD_FS) ? 8'h01 : 8'h06;
    // at superspeed a loaded table still supplies the high-speed interval
    if (nvcfg.nv_present) ivl = (speed == UDR_SPD_FS) ? nvcfg.fs.ivl : nvcfg.hs.ivl;
    if (dt == 8'h05) begin
      d = {8'h07, 8'h05, 8'h83, 8'h03, 8'h10, 8'h00, ivl};
    end else if (dt == 8'h07) begin
      d = {8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, o.str_ld ? o.str_idx : 8'h00,
           o.attr_ld ? o.attr : (8'he0 | nvcfg.attr_flags), o.pwr_ld ? o.pwr : (self_powered ? 8'h01 : 8'hfa)};
    end else if (o.dev_ld) begin
      d = {8'h0a, 8'h06, o.bcd[7:0], o.bcd[15:8], o.dclass, o.dsub, o.dproto, 8'h40, 8'h01, 8'h00};
    end else begin
      d = {8'h0a, 8'h06, 8'h10, 8'h02, 8'hff, 8'h00, 8'hff, 8'h40, 8'h01, 8'h00};
    end
  endfunction

  task automatic one_read(input logic [7:0] dt, input logic [15:0] wl, input logic answer);
    logic [7:0] got[$];
    logic [7:0] exp[$];
    logic st;
    logic ok;
    int n;
    build(dt, exp);
    n = (wl > 16'd255 || int'(wl[7:0]) > exp.size()) ? exp.size() : int'(wl[7:0]);
    host.read_desc(dt, wl, got, st, ok);
    if (!answer) begin
      check(16'(got.size()), 16'h0000);
    end else if (!ok) begin
      n_errors++;
      complete_run();
    end else if (speed == UDR_SPD_SS && dt != 8'h05) begin
      check(16'(st), 16'h0001);
      check(16'(got.size()), 16'h0000);
    end else begin
      check(16'(got.size()), 16'(n));
      for (int i = 0; i < n && i < got.size(); i++) check(16'(got[i]), 16'(exp[i]));
    end
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    logic [7:0] types[3];
    logic [15:0] wls[6];
    logic [191:0] rnd;
    udr_nvcfg_t nv;
    int seed;
    types = '{8'h05, 8'h07, 8'h06};
    wls = '{16'h0001, 16'h0006, 16'h0009, 16'h000a, 16'h00ff, 16'h0123};
    seed = $urandom(44487);
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int it = 0; it < 10; it++) begin
      if (it > 0) begin
        rnd = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
        nv = rnd[160:0];
        if (!nv.nv_present) nv = '0;
        @(posedge core_clk);
        rst <= 1'b1;
        nvcfg <= nv;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
      end
      for (int s = 0; s < 3; s++) begin
        @(posedge core_clk);
        speed <= udr_speed_t'(s);
        self_powered <= 1'(($urandom() >> 3) & 1);
        // the table is re-imaged after a speed change and requests meanwhile are dropped
        repeat (40) @(posedge core_clk);
        if (it == 0 && s == 0) begin
          one_read(8'h02, 16'h0009, 1'b0);
          one_read(8'h05, 16'h0000, 1'b0);
        end
        foreach (types[k]) begin
          one_read(types[k], wls[$urandom_range(0, 5)], 1'b1);
          one_read(types[k], 16'($urandom_range(2, 11)), 1'b1);
        end
      end
    end
    complete_run();
  end
endmodule // tb_usb_descriptor_responder_ep3_qualifier
